// ### rtl/sru_pkg.sv
// shared constants and types for the status reporting unit
package sru_pkg;
  localparam int SRU_W = 16;
  localparam int SRU_GROUPS = 2;
  // group index
  localparam logic SRU_GRP_OPER = 1'h0;
  localparam logic SRU_GRP_QUES = 1'h1;
  // operation condition bit positions
  localparam int SRU_OPER_CAL_BIT = 0;
  localparam int SRU_OPER_ARM_BIT = 6;
  localparam int SRU_OPER_BUSY_BIT = 8;
  localparam int SRU_OPER_READY_BIT = 9;
  // questionable condition bit positions
  localparam int SRU_QUES_VOLT_BIT = 0;
  localparam int SRU_QUES_TIME_BIT = 2;
  localparam int SRU_QUES_CALMEM_BIT = 8;
  // defined bits per group, everything else reads zero
  localparam logic [15:0] SRU_OPER_VALID = 16'h0341;
  localparam logic [15:0] SRU_QUES_VALID = 16'h0105;
  // status byte positions of the group summaries
  localparam int SRU_STB_OPER_BIT = 7;
  localparam int SRU_STB_QUES_BIT = 3;
  // mask range limit and power-on values
  localparam logic [15:0] SRU_MASK_LIMIT = 16'h7FFF;
  localparam logic [15:0] SRU_EN_RESET = 16'h0000;
  localparam logic [15:0] SRU_NTR_RESET = 16'h0000;
  localparam logic [15:0] SRU_PTR_RESET = 16'h7FFF;
  localparam logic [15:0] SRU_EVT_RESET = 16'h0000;
  localparam logic SRU_OPC_MODE_RESET = 1'h1;
  // command codes on the command port
  typedef enum logic [3:0] {
    SRU_CMD_NOP = 4'h0,
    SRU_CMD_WR_EN = 4'h1,
    SRU_CMD_WR_PTR = 4'h2,
    SRU_CMD_WR_NTR = 4'h3,
    SRU_CMD_RD_COND = 4'h4,
    SRU_CMD_RD_EVT = 4'h5,
    SRU_CMD_RD_EN = 4'h6,
    SRU_CMD_RD_PTR = 4'h7,
    SRU_CMD_RD_NTR = 4'h8,
    SRU_CMD_WR_OPC = 4'h9,
    SRU_CMD_RD_OPC = 4'hA,
    SRU_CMD_PRESET = 4'hB,
    SRU_CMD_CLS = 4'hC,
    SRU_CMD_RST = 4'hD,
    SRU_CMD_START = 4'hE,
    SRU_CMD_ABORT = 4'hF
  } sru_cmd_t;
  // completion waiter states
  typedef enum logic [1:0] {
    SRU_OPC_IDLE = 2'b01,
    SRU_OPC_WAIT = 2'b10
  } sru_opc_t;
endpackage

// ### rtl/sru_grp_if.sv
// carrier between the control core and one status group
`timescale 1ns/100ps
interface sru_grp_if;
  logic [15:0] cond_in; // live gated condition
  logic [15:0] pos_mask; // rising edge filter
  logic [15:0] neg_mask; // falling edge filter
  logic [15:0] en_mask; // summary enable mask
  logic evt_clr; // clear event latch this cycle
  logic [15:0] cond_q; // condition register
  logic [15:0] event_q; // event latch
  logic summary; // group summary bit
  modport ctrl (output cond_in, output pos_mask, output neg_mask, output en_mask, output evt_clr,
    input cond_q, input event_q, input summary);
  modport grp (input cond_in, input pos_mask, input neg_mask, input en_mask, input evt_clr,
    output cond_q, output event_q, output summary);
endinterface

// ### rtl/sru_group.sv
// one status group: condition register, transition filters, event latch, summary
`timescale 1ns/100ps
module sru_group
  import sru_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  sru_grp_if.grp gif
);
  logic [15:0] cond_ff; // sampled condition
  logic [15:0] event_ff; // sticky event latch
  logic summary_ff; // registered summary
  logic [15:0] nxt_event; // next latch value
  logic [15:0] edge_set; // qualified transitions
  logic nxt_summary; // next summary

  // rising edges through the positive filter, falling through the negative one
  assign edge_set = (gif.cond_in & ~cond_ff & gif.pos_mask) | (~gif.cond_in & cond_ff & gif.neg_mask);
  // set beats clear so an edge in the read cycle is kept
  assign nxt_event = (gif.evt_clr ? SRU_EVT_RESET : event_ff) | edge_set;
  assign nxt_summary = |(event_ff & gif.en_mask);

  // latches update every cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cond_ff <= 16'h0000;
      event_ff <= SRU_EVT_RESET;
      summary_ff <= 1'h0;
    end
    else
    begin
      cond_ff <= gif.cond_in;
      event_ff <= nxt_event;
      summary_ff <= nxt_summary;
    end
  end

  assign gif.cond_q = cond_ff;
  assign gif.event_q = event_ff;
  assign gif.summary = summary_ff;

  AST_EDGE_LATCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (|edge_set) |=> ((event_ff & $past(edge_set)) == $past(edge_set)))
    else $error("qualified transition not latched");
endmodule

// ### rtl/sru_status_unit.sv
// status reporting unit: masks, condition gating, completion wait, command port
// How it works
// - condition follows hardware; filtered edges set events
// - summary is OR of event AND enable
// - operation summary bit 7, questionable bit 3
// - operation bits 0,6,8,9 only; rest zero
// - bit 0 high while calibration runs
// - bit 6 waiting for arm, cleared on abort
// - bit 8 busy from start until idle
// - bit 9 high when segment accepts data
// - questionable bits 0,2,8 only; rest zero
// - bit 0 input overload during measurement
// - bit 2 sample rate not within 1%
// - bit 8 calibration storage fault
// - condition read leaves contents unchanged
// - event read returns then clears; zero at power-on
// - clear-status clears events; reset leaves them
// - enable masks 0..32767, power-on zero, reset-proof
// - common reset clears conditions except storage fault
// - wait mode off: resolve when parser idle
// - wait mode on: resolve after pending drops
// - pending drops only when trigger idle
// - negative filter sets on falling edge, resets 0
// - positive filter sets on rising edge, resets 32767
// - preset loads masks and turns wait mode on
`timescale 1ns/100ps
module sru_status_unit
  import sru_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_group,
  input wire logic [15:0] cmd_data,
  input wire logic cal_active,
  input wire logic arm_waiting,
  input wire logic meas_done,
  input wire logic seg_ready,
  input wire logic input_overload,
  input wire logic rate_error,
  input wire logic cal_mem_fault,
  input wire logic opc_req,
  input wire logic parser_idle,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [7:0] status_summary,
  output logic opc_done,
  output logic pending_op
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // control state
  logic [15:0] en_ff [SRU_GROUPS]; // summary enable masks
  logic [15:0] ptr_ff [SRU_GROUPS]; // rising edge filters
  logic [15:0] ntr_ff [SRU_GROUPS]; // falling edge filters
  logic opc_mode_ff; // completion wait mode
  logic busy_ff; // busy bit, doubles as the pending flag
  logic hold_ff; // conditions held low after common reset
  sru_opc_t opc_state_ff; // completion waiter
  sru_opc_t nxt_opc_state;
  logic rsp_valid_ff;
  logic [15:0] rsp_data_ff;
  logic [15:0] nxt_rsp_data;
  logic [7:0] stb_ff;
  logic opc_done_ff;
  logic nxt_opc_done;

  // one carrier per group
  sru_grp_if g_if [SRU_GROUPS] ();

  // command decode, one strobe per kind
  sru_cmd_t cmd;
  logic wr_en;
  logic wr_ptr;
  logic wr_ntr;
  logic rd_cond;
  logic rd_evt;
  logic rd_en;
  logic rd_ptr;
  logic rd_ntr;
  logic wr_opc;
  logic rd_opc;
  logic do_preset;
  logic do_cls;
  logic do_rst;
  logic do_start;
  logic do_abort;
  assign cmd = sru_cmd_t'(cmd_code);
  assign wr_en = cmd_valid && (cmd == SRU_CMD_WR_EN);
  assign wr_ptr = cmd_valid && (cmd == SRU_CMD_WR_PTR);
  assign wr_ntr = cmd_valid && (cmd == SRU_CMD_WR_NTR);
  assign rd_cond = cmd_valid && (cmd == SRU_CMD_RD_COND);
  assign rd_evt = cmd_valid && (cmd == SRU_CMD_RD_EVT);
  assign rd_en = cmd_valid && (cmd == SRU_CMD_RD_EN);
  assign rd_ptr = cmd_valid && (cmd == SRU_CMD_RD_PTR);
  assign rd_ntr = cmd_valid && (cmd == SRU_CMD_RD_NTR);
  assign wr_opc = cmd_valid && (cmd == SRU_CMD_WR_OPC);
  assign rd_opc = cmd_valid && (cmd == SRU_CMD_RD_OPC);
  assign do_preset = cmd_valid && (cmd == SRU_CMD_PRESET);
  assign do_cls = cmd_valid && (cmd == SRU_CMD_CLS);
  assign do_rst = cmd_valid && (cmd == SRU_CMD_RST);
  assign do_start = cmd_valid && (cmd == SRU_CMD_START);
  assign do_abort = cmd_valid && (cmd == SRU_CMD_ABORT);

  // any response-producing command
  logic any_rd;
  assign any_rd = rd_cond | rd_evt | rd_en | rd_ptr | rd_ntr | rd_opc;

  // masks are limited to 15 bits; the top bit is dropped on write
  logic [15:0] mask_wdata;
  assign mask_wdata = cmd_data & SRU_MASK_LIMIT;

  // busy only ends when the trigger system is idle again
  logic busy_clr;
  assign busy_clr = meas_done | do_abort | do_rst;

  // live operation conditions, gated by busy and the reset hold
  logic [15:0] oper_live;
  always_comb
  begin
    oper_live = 16'h0000;
    oper_live[SRU_OPER_CAL_BIT] = cal_active & ~hold_ff;
    oper_live[SRU_OPER_ARM_BIT] = arm_waiting & busy_ff;
    oper_live[SRU_OPER_BUSY_BIT] = busy_ff;
    oper_live[SRU_OPER_READY_BIT] = seg_ready & ~hold_ff;
  end

  // live questionable conditions; storage fault ignores the reset hold
  logic [15:0] ques_live;
  always_comb
  begin
    ques_live = 16'h0000;
    ques_live[SRU_QUES_VOLT_BIT] = input_overload & busy_ff;
    ques_live[SRU_QUES_TIME_BIT] = rate_error & ~hold_ff;
    ques_live[SRU_QUES_CALMEM_BIT] = cal_mem_fault;
  end

  // undefined positions forced to zero whatever the sources do
  assign g_if[SRU_GRP_OPER].cond_in = oper_live & SRU_OPER_VALID;
  assign g_if[SRU_GRP_QUES].cond_in = ques_live & SRU_QUES_VALID;

  // per-group mask registers and group instance
  genvar gi;
  generate
    for (gi = 0; gi < SRU_GROUPS; gi++)
    begin : g_grp
      logic sel;
      assign sel = (cmd_group == 1'(gi));
      assign g_if[gi].pos_mask = ptr_ff[gi];
      assign g_if[gi].neg_mask = ntr_ff[gi];
      assign g_if[gi].en_mask = en_ff[gi];
      // read clears only the addressed group; clear-status hits both
      assign g_if[gi].evt_clr = (rd_evt & sel) | do_cls;

      // masks: power-on values, preset values, common reset leaves them
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          en_ff[gi] <= SRU_EN_RESET;
          ptr_ff[gi] <= SRU_PTR_RESET;
          ntr_ff[gi] <= SRU_NTR_RESET;
        end
        else if (do_preset)
        begin
          en_ff[gi] <= SRU_EN_RESET;
          ptr_ff[gi] <= SRU_PTR_RESET;
          ntr_ff[gi] <= SRU_NTR_RESET;
        end
        else
        begin
          if (wr_en && sel)
            en_ff[gi] <= mask_wdata;
          if (wr_ptr && sel)
            ptr_ff[gi] <= mask_wdata;
          if (wr_ntr && sel)
            ntr_ff[gi] <= mask_wdata;
        end
      end

      sru_group u_group (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .gif(g_if[gi])
      );
    end
  endgenerate

  // response mux for reads; the event value is the one before clearing
  logic [15:0] sel_cond;
  logic [15:0] sel_evt;
  logic [15:0] sel_en;
  logic [15:0] sel_ptr;
  logic [15:0] sel_ntr;
  assign sel_cond = cmd_group ? g_if[SRU_GRP_QUES].cond_q : g_if[SRU_GRP_OPER].cond_q;
  assign sel_evt = cmd_group ? g_if[SRU_GRP_QUES].event_q : g_if[SRU_GRP_OPER].event_q;
  assign sel_en = cmd_group ? en_ff[SRU_GRP_QUES] : en_ff[SRU_GRP_OPER];
  assign sel_ptr = cmd_group ? ptr_ff[SRU_GRP_QUES] : ptr_ff[SRU_GRP_OPER];
  assign sel_ntr = cmd_group ? ntr_ff[SRU_GRP_QUES] : ntr_ff[SRU_GRP_OPER];
  assign nxt_rsp_data = rd_cond ? sel_cond :
                        rd_evt ? sel_evt :
                        rd_en ? sel_en :
                        rd_ptr ? sel_ptr :
                        rd_ntr ? sel_ntr :
                        rd_opc ? {15'h0000, opc_mode_ff} : rsp_data_ff;

  // mode, busy and the reset hold
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opc_mode_ff <= SRU_OPC_MODE_RESET;
      busy_ff <= 1'h0;
      hold_ff <= 1'h0;
    end
    else
    begin
      // preset forces the wait mode on; common reset leaves it
      if (do_preset)
        opc_mode_ff <= 1'h1;
      else if (wr_opc)
        opc_mode_ff <= cmd_data[0];
      // start raises busy and the pending flag
      if (do_start)
        busy_ff <= 1'h1;
      else if (busy_clr)
        busy_ff <= 1'h0;
      // hold conditions low after reset until the next start
      if (do_rst)
        hold_ff <= 1'h1;
      else if (do_start)
        hold_ff <= 1'h0;
    end
  end

  // completion waiter: a request resolves once the parser is idle
  // and, in wait mode, once the pending flag has dropped
  logic opc_ready;
  logic opc_seen;
  assign opc_ready = parser_idle & (~opc_mode_ff | ~busy_ff);
  assign opc_seen = opc_req | (opc_state_ff == SRU_OPC_WAIT);
  always_comb
  begin
    nxt_opc_state = opc_state_ff;
    nxt_opc_done = 1'h0;
    unique case (opc_state_ff)
      SRU_OPC_IDLE:
        if (opc_req && opc_ready)
          nxt_opc_done = 1'h1;
        else if (opc_req)
          nxt_opc_state = SRU_OPC_WAIT;
      SRU_OPC_WAIT:
        if (opc_ready)
        begin
          nxt_opc_done = 1'h1;
          nxt_opc_state = SRU_OPC_IDLE;
        end
      default:
        nxt_opc_state = SRU_OPC_IDLE;
    endcase
  end

  // output flops; the status byte lags the summaries by one cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opc_state_ff <= SRU_OPC_IDLE;
      opc_done_ff <= 1'h0;
      rsp_valid_ff <= 1'h0;
      rsp_data_ff <= 16'h0000;
      stb_ff <= 8'h00;
    end
    else
    begin
      opc_state_ff <= nxt_opc_state;
      opc_done_ff <= nxt_opc_done;
      rsp_valid_ff <= any_rd;
      rsp_data_ff <= nxt_rsp_data;
      stb_ff <= 8'h00;
      stb_ff[SRU_STB_OPER_BIT] <= g_if[SRU_GRP_OPER].summary;
      stb_ff[SRU_STB_QUES_BIT] <= g_if[SRU_GRP_QUES].summary;
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign status_summary = stb_ff;
  assign opc_done = opc_done_ff;
  assign pending_op = busy_ff;

  // named steps for the completion checks
  sequence s_req_off;
    opc_req && (opc_state_ff == SRU_OPC_IDLE) && parser_idle && !opc_mode_ff;
  endsequence
  sequence s_wait_busy;
    opc_seen && opc_mode_ff && busy_ff;
  endsequence

  AST_STB_OPER: assert property (
    stb_ff[SRU_STB_OPER_BIT] == $past(|(g_if[0].event_q & g_if[0].en_mask), 2))
    else $error("operation summary wrong in status byte");
  AST_STB_QUES: assert property (
    stb_ff[SRU_STB_QUES_BIT] == $past(|(g_if[1].event_q & g_if[1].en_mask), 2))
    else $error("questionable summary wrong in status byte");
  AST_OPER_UNDEF: assert property (
    (g_if[0].cond_q & ~SRU_OPER_VALID) == 16'h0000 && (g_if[0].event_q & ~SRU_OPER_VALID) == 16'h0000)
    else $error("undefined operation bit set");
  AST_QUES_UNDEF: assert property (
    (g_if[1].cond_q & ~SRU_QUES_VALID) == 16'h0000)
    else $error("undefined questionable bit set");
  AST_BUSY_START: assert property (
    do_start |=> busy_ff ##1 g_if[0].cond_q[SRU_OPER_BUSY_BIT])
    else $error("start did not raise busy");
  AST_COND_READ: assert property (
    rd_cond |=> rsp_valid_ff && rsp_data_ff == $past(sel_cond))
    else $error("condition read returned wrong value");
  AST_EVT_READ: assert property (
    rd_evt && !cmd_group && g_if[0].cond_in == g_if[0].cond_q
    |=> rsp_data_ff == $past(g_if[0].event_q) && g_if[0].event_q == 16'h0000)
    else $error("event read did not return and clear");
  AST_CLS: assert property (
    do_cls && g_if[1].cond_in == g_if[1].cond_q |=> g_if[1].event_q == 16'h0000)
    else $error("clear-status left questionable events");
  AST_PRESET: assert property (
    do_preset |=> ptr_ff[0] == SRU_PTR_RESET && ntr_ff[1] == SRU_NTR_RESET && en_ff[0] == SRU_EN_RESET
      && opc_mode_ff)
    else $error("preset values not loaded");
  AST_MASK_RANGE: assert property (
    en_ff[0][15] == 1'h0 && en_ff[1][15] == 1'h0)
    else $error("enable mask above range");
  AST_OPC_OFF: assert property (
    s_req_off |=> opc_done_ff)
    else $error("completion not immediate with wait mode off");
  AST_OPC_WAIT: assert property (
    s_wait_busy |=> !opc_done_ff)
    else $error("completion resolved while pending");
endmodule

// ### test/tb.sv
// self-checking bench for the status reporting unit command and status paths
`timescale 1ns/100ps
module tb;
  import sru_pkg::*;
  logic clk_sys = 1'h0; // 50 MHz system clock
  logic reset_n = 1'h0; // active low reset
  logic cmd_valid = 1'h0;
  logic [3:0] cmd_code = 4'h0;
  logic cmd_group = 1'h0;
  logic [15:0] cmd_data = 16'h0000;
  logic cal_active = 1'h0;
  logic arm_waiting = 1'h0;
  logic meas_done = 1'h0;
  logic seg_ready = 1'h0;
  logic input_overload = 1'h0;
  logic rate_error = 1'h0;
  logic cal_mem_fault = 1'h0;
  logic opc_req = 1'h0;
  logic parser_idle = 1'h1;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [7:0] status_summary;
  logic opc_done;
  logic pending_op;
  int failures = 0; // mismatches seen
  int checks_done = 0; // comparisons made
  bit seen; // opc_done observed in a watch window
  sru_status_unit u_sru_status_unit (.clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_group(cmd_group), .cmd_data(cmd_data), .cal_active(cal_active),
    .arm_waiting(arm_waiting), .meas_done(meas_done), .seg_ready(seg_ready),
    .input_overload(input_overload), .rate_error(rate_error), .cal_mem_fault(cal_mem_fault),
    .opc_req(opc_req), .parser_idle(parser_idle), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .status_summary(status_summary), .opc_done(opc_done), .pending_op(pending_op));
  // clock, half period 10 ns
  always #10 clk_sys = ~clk_sys;
  // verdict and end of run, shared by sequence and watchdog
  task final_report();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // word compare, four-state exact
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // status byte compare
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask
  // flag compare
  task chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  // one command: strobe held for exactly one rising edge
  task cmd(input sru_cmd_t c, input logic g, input logic [15:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'h1;
    cmd_code = c;
    cmd_group = g;
    cmd_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'h0;
  endtask
  // read: answer stands from the taking edge for one cycle, looked at half a cycle after that edge
  task rd(input sru_cmd_t c, input logic g, input logic [15:0] e);
    cmd(c, g, 16'h0000);
    chk1(rsp_valid, 1'h1);
    chk16(rsp_data, e);
  endtask
  // idle cycles, lets condition edges reach events and status byte
  task idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // watch opc_done for the current and n more cycles
  task watch(input int n, output bit s);
    s = (opc_done === 1'h1);
    repeat (n)
    begin
      @(negedge clk_sys);
      if (opc_done === 1'h1)
        s = 1'h1;
    end
  endtask
  // completion request pulse
  task opc_pulse();
    @(negedge clk_sys);
    opc_req = 1'h1;
    @(negedge clk_sys);
    opc_req = 1'h0;
  endtask
  // watchdog, run needs well under 1000 cycles
  initial
  begin
    #(20 * 5000);
    failures++;
    final_report();
  end
  // main sequence
  initial
  begin
    idle(8);
    reset_n = 1'h1;
    // power-on register values, both groups
    for (int g = 0; g < 2; g++)
    begin
      rd(SRU_CMD_RD_EN, g[0], 16'h0000);
      rd(SRU_CMD_RD_PTR, g[0], 16'h7FFF);
      rd(SRU_CMD_RD_NTR, g[0], 16'h0000);
      rd(SRU_CMD_RD_EVT, g[0], 16'h0000);
    end
    rd(SRU_CMD_RD_OPC, 1'h0, 16'h0001);
    chk8(status_summary, 8'h00);
    $display("test power_on done");
    // every defined condition raised, undefined bits stay zero
    cmd(SRU_CMD_START, 1'h0, 16'h0000);
    cal_active = 1'h1;
    arm_waiting = 1'h1;
    seg_ready = 1'h1;
    input_overload = 1'h1;
    rate_error = 1'h1;
    cal_mem_fault = 1'h1;
    idle(3);
    rd(SRU_CMD_RD_COND, 1'h0, 16'h0341);
    rd(SRU_CMD_RD_COND, 1'h0, 16'h0341);
    rd(SRU_CMD_RD_COND, 1'h1, 16'h0105);
    chk1(pending_op, 1'h1);
    rd(SRU_CMD_RD_EVT, 1'h0, 16'h0341);
    rd(SRU_CMD_RD_EVT, 1'h0, 16'h0000);
    rd(SRU_CMD_RD_EVT, 1'h1, 16'h0105);
    rd(SRU_CMD_RD_EVT, 1'h1, 16'h0000);
    $display("test conditions done");
    // falling filter only; mask bit 15 dropped
    cmd(SRU_CMD_WR_NTR, 1'h0, 16'hFFFF);
    rd(SRU_CMD_RD_NTR, 1'h0, 16'h7FFF);
    cmd(SRU_CMD_WR_PTR, 1'h0, 16'h0000);
    cal_active = 1'h0;
    cmd(SRU_CMD_ABORT, 1'h0, 16'h0000);
    idle(3);
    rd(SRU_CMD_RD_EVT, 1'h0, 16'h0141);
    rd(SRU_CMD_RD_COND, 1'h0, 16'h0200);
    chk1(pending_op, 1'h0);
    cmd(SRU_CMD_WR_EN, 1'h0, 16'hFFFF);
    rd(SRU_CMD_RD_EN, 1'h0, 16'h7FFF);
    $display("test falling_filter done");
    // summary bits follow event AND enable
    seg_ready = 1'h0;
    idle(4);
    chk8(status_summary, 8'h80);
    cmd(SRU_CMD_WR_EN, 1'h0, 16'h0100);
    idle(3);
    chk8(status_summary, 8'h00);
    cmd(SRU_CMD_WR_EN, 1'h0, 16'h0200);
    idle(3);
    chk8(status_summary, 8'h80);
    cmd(SRU_CMD_CLS, 1'h0, 16'h0000);
    idle(3);
    chk8(status_summary, 8'h00);
    rd(SRU_CMD_RD_EVT, 1'h0, 16'h0000);
    cmd(SRU_CMD_WR_EN, 1'h1, 16'h0004);
    rate_error = 1'h0;
    idle(2);
    rate_error = 1'h1;
    idle(4);
    chk8(status_summary, 8'h08);
    $display("test summary done");
    // common reset: conditions cleared except storage fault
    cmd(SRU_CMD_WR_NTR, 1'h0, 16'h0000);
    cmd(SRU_CMD_START, 1'h0, 16'h0000);
    seg_ready = 1'h1;
    idle(3);
    cmd(SRU_CMD_RST, 1'h0, 16'h0000);
    idle(3);
    rd(SRU_CMD_RD_COND, 1'h0, 16'h0000);
    rd(SRU_CMD_RD_COND, 1'h1, 16'h0100);
    chk1(pending_op, 1'h0);
    chk8(status_summary, 8'h08);
    rd(SRU_CMD_RD_EN, 1'h1, 16'h0004);
    rd(SRU_CMD_RD_EN, 1'h0, 16'h0200);
    rd(SRU_CMD_RD_EVT, 1'h1, 16'h0005);
    $display("test common_reset done");
    // completion wait mode on: done only after pending drops
    cmd(SRU_CMD_START, 1'h0, 16'h0000);
    opc_pulse();
    watch(10, seen);
    chk1(seen, 1'h0);
    rd(SRU_CMD_RD_COND, 1'h0, 16'h0340);
    arm_waiting = 1'h0;
    idle(2);
    rd(SRU_CMD_RD_COND, 1'h0, 16'h0300);
    @(negedge clk_sys);
    meas_done = 1'h1;
    @(negedge clk_sys);
    meas_done = 1'h0;
    watch(3, seen);
    chk1(seen, 1'h1);
    chk1(pending_op, 1'h0);
    // mode off: done once parser idle, measurement still running
    cmd(SRU_CMD_WR_OPC, 1'h0, 16'h0000);
    rd(SRU_CMD_RD_OPC, 1'h0, 16'h0000);
    cmd(SRU_CMD_START, 1'h0, 16'h0000);
    opc_pulse();
    watch(3, seen);
    chk1(seen, 1'h1);
    chk1(pending_op, 1'h1);
    parser_idle = 1'h0;
    opc_pulse();
    watch(5, seen);
    chk1(seen, 1'h0);
    parser_idle = 1'h1;
    watch(3, seen);
    chk1(seen, 1'h1);
    $display("test completion done");
    // preset restores masks and wait mode
    cmd(SRU_CMD_WR_NTR, 1'h1, 16'h0011);
    cmd(SRU_CMD_PRESET, 1'h0, 16'h0000);
    rd(SRU_CMD_RD_OPC, 1'h0, 16'h0001);
    for (int g = 0; g < 2; g++)
    begin
      rd(SRU_CMD_RD_EN, g[0], 16'h0000);
      rd(SRU_CMD_RD_NTR, g[0], 16'h0000);
      rd(SRU_CMD_RD_PTR, g[0], 16'h7FFF);
    end
    cmd(SRU_CMD_ABORT, 1'h0, 16'h0000);
    $display("test preset done");
    final_report();
  end
endmodule
